/* File: tx_driver_enable_and_block_irq.v */
// Functional notes
// - Channel-1 driver bit drives or tri-states its pair
// - Channel-0 driver bit drives or tri-states its pair
// - Eight-bit channel gate register, resets to zero
// - Gate bit 2 clear blocks new channel-2 interrupts; one already pending stays set
// - Interrupt needs channel gate and source enable
// - Bits 2..0 gate channels; 7..3 read zero
// - Read-only pending register, one bit per channel
// - Pending bit high while channel interrupt awaits
// - Pending stays set until source status read
`timescale 1ns/1ps
`include "irq_gate_defs.vh"

module tx_driver_enable_and_block_irq (
    input  wire                            aclk,
    input  wire                            aresetn,
    input  wire [`ADDR_W-1:0]              s_axi_awaddr,
    input  wire                            s_axi_awvalid,
    output wire                            s_axi_awready,
    input  wire [31:0]                     s_axi_wdata,
    input  wire [3:0]                      s_axi_wstrb,
    input  wire                            s_axi_wvalid,
    output wire                            s_axi_wready,
    output wire [1:0]                      s_axi_bresp,
    output wire                            s_axi_bvalid,
    input  wire                            s_axi_bready,
    input  wire [`ADDR_W-1:0]              s_axi_araddr,
    input  wire                            s_axi_arvalid,
    output wire                            s_axi_arready,
    output wire [31:0]                     s_axi_rdata,
    output wire [1:0]                      s_axi_rresp,
    output wire                            s_axi_rvalid,
    input  wire                            s_axi_rready,
    input  wire [`NUM_CH*`NUM_SRC-1:0]     src_event,
    input  wire                            driver_on_pin_ch1,
    input  wire                            driver_on_pin_ch0,
    input  wire                            tx_pos_ch1,
    input  wire                            tx_neg_ch1,
    input  wire                            tx_pos_ch0,
    input  wire                            tx_neg_ch0,
    output wire                            line_out_pos_ch1,
    output wire                            line_out_neg_ch1,
    output wire                            line_out_oe_ch1,
    output wire                            line_out_pos_ch0,
    output wire                            line_out_neg_ch0,
    output wire                            line_out_oe_ch0,
    output wire                            irq
);

    wire                          wr_fire;
    wire [`ADDR_W-1:0]            wr_addr;
    wire [`REG_W-1:0]             wr_data;
    wire                          wr_lane0;
    wire                          rd_fire;
    wire [`ADDR_W-1:0]            rd_addr;
    reg  [`REG_W-1:0]             rd_data;
    reg                           rd_err;
    reg                           wr_err;

    reg  [`REG_W-1:0]             line_section_power_q;
    reg  [`REG_W-1:0]             channel_irq_gate_q;
    reg  [`NUM_CH-1:0]            irq_event_status_q;
    reg  [`NUM_CH-1:0]            irq_event_mask_q;
    reg  [`NUM_CH-1:0]            pend_prev_q;
    wire [`NUM_CH-1:0]            channel_irq_pending;
    wire [`NUM_CH*`NUM_SRC-1:0]   src_enable;
    wire [`NUM_CH*`NUM_SRC-1:0]   src_status;
    wire [`NUM_CH-1:0]            src_en_wr;
    wire [`NUM_CH-1:0]            src_st_rd;

    reg  [`NUM_DRV-1:0]           pin_meta_q;
    reg  [`NUM_DRV-1:0]           pin_sync_q;
    reg  [`NUM_DRV-1:0]           out_pos_q;
    reg  [`NUM_DRV-1:0]           out_neg_q;
    reg  [`NUM_DRV-1:0]           out_oe_q;
    wire [`NUM_DRV-1:0]           pin_raw;
    wire [`NUM_DRV-1:0]           tx_pos;
    wire [`NUM_DRV-1:0]           tx_neg;
    wire [`NUM_DRV-1:0]           drive_on;
    wire [`NUM_CH-1:0]            pend_rise;
    wire [`ADDR_W-1:0]            rd_idx;
    wire [`ADDR_W-1:0]            wr_idx;
    wire                          wr_en;
    wire                          wr_pwr;
    wire                          wr_gate;
    wire                          wr_evs;
    wire                          wr_evm;

    // Word index from a byte address
    function [`ADDR_W-1:0] word_idx;
        input [`ADDR_W-1:0] a;
        begin
            word_idx = a >> `WORD_SHIFT;
        end
    endfunction

    // Index hit on a per-channel bank; returns one-hot channel select
    function [`NUM_CH-1:0] bank_hit;
        input [`ADDR_W-1:0] idx;
        input [`ADDR_W-1:0] base;
        integer k;
        begin
            bank_hit = {`NUM_CH{1'b0}};
            for (k = 0; k < `NUM_CH; k = k + 1)
                if (idx == base + k[`ADDR_W-1:0])
                    bank_hit[k] = 1'b1;
        end
    endfunction

    axil_slave u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_fire       (wr_fire),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_lane0      (wr_lane0),
        .wr_err        (wr_err),
        .rd_fire       (rd_fire),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    // Decoded once, shared by the register, error and bank logic
    assign rd_idx  = word_idx(rd_addr);
    assign wr_idx  = word_idx(wr_addr);
    // Low byte lane carries every register
    assign wr_en   = wr_fire && wr_lane0;
    assign wr_pwr  = wr_en && wr_idx == `IDX_LINE_SECTION_POWER;
    assign wr_gate = wr_en && wr_idx == `IDX_CHANNEL_IRQ_GATE;
    assign wr_evs  = wr_en && wr_idx == `IDX_IRQ_EVENT_STATUS;
    assign wr_evm  = wr_en && wr_idx == `IDX_IRQ_EVENT_MASK;

    assign src_en_wr = wr_en ?
                       bank_hit(wr_idx, `IDX_SRC_ENABLE_BASE) :
                       {`NUM_CH{1'b0}};
    assign src_st_rd = rd_fire ?
                       bank_hit(rd_idx, `IDX_SRC_STATUS_BASE) :
                       {`NUM_CH{1'b0}};

    genvar c;
    generate
        for (c = 0; c < `NUM_CH; c = c + 1)
        begin : g_ch
            chan_irq_unit u_unit (
                .aclk       (aclk),
                .aresetn    (aresetn),
                .src_event  (src_event[c*`NUM_SRC +: `NUM_SRC]),
                .en_wr      (src_en_wr[c]),
                .en_data    (wr_data[`NUM_SRC-1:0]),
                .status_rd  (src_st_rd[c]),
                .block_en   (channel_irq_gate_q[c]),
                .src_enable (src_enable[c*`NUM_SRC +: `NUM_SRC]),
                .src_status (src_status[c*`NUM_SRC +: `NUM_SRC]),
                .pending    (channel_irq_pending[c])
            );
        end
    endgenerate

    // Read decode; unmapped indices answer with an error and zero data
    always @*
    begin
        rd_data = `REG_RESET;
        rd_err  = 1'b0;
        if (rd_idx == `IDX_LINE_SECTION_POWER)
            rd_data = line_section_power_q;
        else if (rd_idx == `IDX_CHANNEL_IRQ_GATE)
            rd_data = channel_irq_gate_q;
        else if (rd_idx == `IDX_CHANNEL_IRQ_PENDING)
            rd_data = {{(`REG_W-`NUM_CH){1'b0}}, channel_irq_pending};
        else if (rd_idx == `IDX_IRQ_EVENT_STATUS)
            rd_data = {{(`REG_W-`NUM_CH){1'b0}}, irq_event_status_q};
        else if (rd_idx == `IDX_IRQ_EVENT_MASK)
            rd_data = {{(`REG_W-`NUM_CH){1'b0}}, irq_event_mask_q};
        else if (|bank_hit(rd_idx, `IDX_SRC_ENABLE_BASE))
            rd_data = pick_src(src_enable, bank_hit(rd_idx, `IDX_SRC_ENABLE_BASE));
        else if (|src_st_rd || |bank_hit(rd_idx, `IDX_SRC_STATUS_BASE))
            rd_data = pick_src(src_status, bank_hit(rd_idx, `IDX_SRC_STATUS_BASE));
        else
            rd_err = 1'b1;
    end

    // Select one channel's source field, zero-extended
    function [`REG_W-1:0] pick_src;
        input [`NUM_CH*`NUM_SRC-1:0] v;
        input [`NUM_CH-1:0]          sel;
        integer k;
        begin
            pick_src = `REG_RESET;
            for (k = 0; k < `NUM_CH; k = k + 1)
                if (sel[k])
                    pick_src = {{(`REG_W-`NUM_SRC){1'b0}}, v[k*`NUM_SRC +: `NUM_SRC]};
        end
    endfunction

    // Writes to read-only or unmapped words are refused with an error
    always @*
    begin
        wr_err = 1'b1;
        if (wr_idx == `IDX_LINE_SECTION_POWER)
            wr_err = 1'b0;
        else if (wr_idx == `IDX_CHANNEL_IRQ_GATE)
            wr_err = 1'b0;
        else if (wr_idx == `IDX_IRQ_EVENT_STATUS)
            wr_err = 1'b0;
        else if (wr_idx == `IDX_IRQ_EVENT_MASK)
            wr_err = 1'b0;
        else if (|bank_hit(wr_idx, `IDX_SRC_ENABLE_BASE))
            wr_err = 1'b0;
    end

    // Edge of pending, so a long-held request raises one event only
    assign pend_rise = channel_irq_pending & ~pend_prev_q;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            line_section_power_q <= `REG_RESET;
            channel_irq_gate_q   <= `REG_RESET;
            irq_event_mask_q     <= `CH_RESET;
            pend_prev_q          <= `CH_RESET;
        end
        else
        begin
            pend_prev_q <= channel_irq_pending;
            if (wr_pwr)
                line_section_power_q <= wr_data & `POWER_MASK;
            if (wr_gate)
                channel_irq_gate_q <= wr_data & `GATE_MASK;
            if (wr_evm)
                irq_event_mask_q <= wr_data[`NUM_CH-1:0];
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
            irq_event_status_q <= `CH_RESET;
        // Write-one-to-clear; a rising edge in the same cycle wins
        else if (wr_evs)
            irq_event_status_q <= (irq_event_status_q & ~wr_data[`NUM_CH-1:0])
                                  | pend_rise;
        else
            irq_event_status_q <= irq_event_status_q | pend_rise;
    end

    // Level output; drops once the event is cleared or masked
    assign irq = |(irq_event_status_q & irq_event_mask_q);

    // Driver pins come from the board, so they are synchronised first
    assign pin_raw = {driver_on_pin_ch1, driver_on_pin_ch0};
    assign tx_pos  = {tx_pos_ch1, tx_pos_ch0};
    assign tx_neg  = {tx_neg_ch1, tx_neg_ch0};
    // Pin low overrides software; pin high hands control to the bit
    assign drive_on = pin_sync_q & line_section_power_q[`NUM_DRV-1:0];

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_meta_q <= `DRV_RESET;
            pin_sync_q <= `DRV_RESET;
            out_pos_q  <= `DRV_RESET;
            out_neg_q  <= `DRV_RESET;
            out_oe_q   <= `DRV_RESET;
        end
        else
        begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
            // Data held low while off so a released pair carries no pulse
            out_pos_q  <= tx_pos & drive_on;
            out_neg_q  <= tx_neg & drive_on;
            out_oe_q   <= drive_on;
        end
    end

    assign line_out_pos_ch1 = out_pos_q[1];
    assign line_out_neg_ch1 = out_neg_q[1];
    assign line_out_oe_ch1  = out_oe_q[1];
    assign line_out_pos_ch0 = out_pos_q[0];
    assign line_out_neg_ch0 = out_neg_q[0];
    assign line_out_oe_ch0  = out_oe_q[0];

endmodule

/* File: irq_gate_defs.vh */
`ifndef IRQ_GATE_DEFS_VH
`define IRQ_GATE_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_LINE_SECTION_POWER  8'h01
`define IDX_SRC_ENABLE_BASE     8'h10
`define IDX_SRC_STATUS_BASE     8'h18
`define IDX_CHANNEL_IRQ_GATE    8'h20
`define IDX_CHANNEL_IRQ_PENDING 8'h21
`define IDX_IRQ_EVENT_STATUS    8'h28
`define IDX_IRQ_EVENT_MASK      8'h29

`define ADDR_W        8
`define WORD_SHIFT    2
`define NUM_CH        3
`define NUM_DRV       2
`define NUM_SRC       4
`define REG_W         8

`define GATE_MASK     8'h07
`define POWER_MASK    8'h03
`define REG_RESET     8'h00
`define SRC_RESET     4'h0
`define CH_RESET      3'h0
`define DRV_RESET     2'h0

`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

/* File: axil_slave.v */
`timescale 1ns/1ps
`include "irq_gate_defs.vh"

module axil_slave (
    input  wire                aclk,
    input  wire                aresetn,
    input  wire [`ADDR_W-1:0]  s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output wire                s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output wire                s_axi_wready,
    output wire [1:0]          s_axi_bresp,
    output wire                s_axi_bvalid,
    input  wire                s_axi_bready,
    input  wire [`ADDR_W-1:0]  s_axi_araddr,
    input  wire                s_axi_arvalid,
    output wire                s_axi_arready,
    output wire [31:0]         s_axi_rdata,
    output wire [1:0]          s_axi_rresp,
    output wire                s_axi_rvalid,
    input  wire                s_axi_rready,
    output wire                wr_fire,
    output wire [`ADDR_W-1:0]  wr_addr,
    output wire [`REG_W-1:0]   wr_data,
    output wire                wr_lane0,
    input  wire                wr_err,
    output wire                rd_fire,
    output wire [`ADDR_W-1:0]  rd_addr,
    input  wire [`REG_W-1:0]   rd_data,
    input  wire                rd_err
);

    reg                aw_held_q;
    reg  [`ADDR_W-1:0] aw_addr_q;
    reg                w_held_q;
    reg  [`REG_W-1:0]  w_data_q;
    reg                w_lane_q;
    reg                bvalid_q;
    reg  [1:0]         bresp_q;
    reg                rvalid_q;
    reg  [`REG_W-1:0]  rdata_q;
    reg  [1:0]         rresp_q;
    wire               aw_take;
    wire               w_take;
    wire               aw_ok;
    wire               w_ok;

    // Address and data taken in either order; response only after both
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign aw_ok         = aw_held_q || aw_take;
    assign w_ok          = w_held_q || w_take;
    assign wr_fire       = aw_ok && w_ok;
    assign wr_addr       = aw_held_q ? aw_addr_q : s_axi_awaddr;
    assign wr_data       = w_held_q ? w_data_q : s_axi_wdata[`REG_W-1:0];
    assign wr_lane0      = w_held_q ? w_lane_q : s_axi_wstrb[0];

    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign rd_fire       = s_axi_arvalid && !rvalid_q;
    assign rd_addr       = s_axi_araddr;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = {{(32-`REG_W){1'b0}}, rdata_q};
    assign s_axi_rresp   = rresp_q;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= {`ADDR_W{1'b0}};
            w_held_q  <= 1'b0;
            w_data_q  <= `REG_RESET;
            w_lane_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= `REG_RESET;
            rresp_q   <= `RESP_OKAY;
        end
        else
        begin
            if (aw_take && !wr_fire)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take && !wr_fire)
            begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata[`REG_W-1:0];
                w_lane_q <= s_axi_wstrb[0];
            end
            if (wr_fire)
            begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
            if (rd_fire)
            begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_data;
                rresp_q  <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

endmodule

/* File: chan_irq_unit.v */
`timescale 1ns/1ps
`include "irq_gate_defs.vh"

module chan_irq_unit (
    input  wire                aclk,
    input  wire                aresetn,
    input  wire [`NUM_SRC-1:0] src_event,
    input  wire                en_wr,
    input  wire [`NUM_SRC-1:0] en_data,
    input  wire                status_rd,
    input  wire                block_en,
    output wire [`NUM_SRC-1:0] src_enable,
    output wire [`NUM_SRC-1:0] src_status,
    output wire                pending
);

    reg  [`NUM_SRC-1:0] enable_q;
    reg  [`NUM_SRC-1:0] status_q;
    reg                 pending_q;
    wire                gated;

    assign src_enable = enable_q;
    assign src_status = status_q;
    assign pending    = pending_q;
    // Nothing reaches the block level unless both enables agree
    assign gated = block_en && |(status_q & enable_q);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_q  <= `SRC_RESET;
            status_q  <= `SRC_RESET;
            pending_q <= 1'b0;
        end
        else
        begin
            if (en_wr)
                enable_q <= en_data;
            // Read clears what was seen; a new event in that cycle survives
            status_q <= (status_rd ? `SRC_RESET : status_q) | src_event;
            // Sticky until the source status read, which also empties the status
            pending_q <= !status_rd && (gated || pending_q);
        end
    end

endmodule

/* File: irq_gate_chk.sv */
`timescale 1ns/1ps
`include "irq_gate_defs.vh"

module irq_gate_chk (
    input wire logic                        aclk,
    input wire logic                        aresetn,
    input wire logic [`ADDR_W-1:0]          s_axi_araddr,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [31:0]                 s_axi_rdata,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_bvalid,
    input wire logic [`NUM_CH*`NUM_SRC-1:0] src_event,
    input wire logic                        driver_on_pin_ch1,
    input wire logic                        driver_on_pin_ch0,
    input wire logic                        tx_pos_ch1,
    input wire logic                        tx_neg_ch1,
    input wire logic                        tx_pos_ch0,
    input wire logic                        tx_neg_ch0,
    input wire logic                        line_out_pos_ch1,
    input wire logic                        line_out_neg_ch1,
    input wire logic                        line_out_oe_ch1,
    input wire logic                        line_out_pos_ch0,
    input wire logic                        line_out_neg_ch0,
    input wire logic                        line_out_oe_ch0,
    input wire logic                        irq
);
    localparam [7:0] gate_a = `IDX_CHANNEL_IRQ_GATE << `WORD_SHIFT;
    localparam [7:0] pend_a = `IDX_CHANNEL_IRQ_PENDING << `WORD_SHIFT;
    logic [7:0] ar_q;
    logic [2:0] ev_q;

    // Channels that have seen any event since reset; pending cannot exist without one
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ar_q <= 8'h00;
            ev_q <= 3'h0;
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready)
                ar_q <= s_axi_araddr;
            ev_q <= ev_q | {|src_event[11:8], |src_event[7:4], |src_event[3:0]};
        end
    end

    // Reset itself is the cause here, so no disable
    reset_quiet_a: assert property (@(posedge aclk) !aresetn |=> !irq && !line_out_oe_ch1
        && !line_out_oe_ch0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not quiet after reset");
    drive_pin1_a: assert property (@(posedge aclk) disable iff (!aresetn)
        line_out_oe_ch1 |-> $past(driver_on_pin_ch1, 3))
        else $error("ch1 driven without pin");
    drive_pin0_a: assert property (@(posedge aclk) disable iff (!aresetn)
        line_out_oe_ch0 |-> $past(driver_on_pin_ch0, 3))
        else $error("ch0 driven without pin");
    line_data1_a: assert property (@(posedge aclk) disable iff (!aresetn)
        {line_out_pos_ch1, line_out_neg_ch1} ==
        ({2{line_out_oe_ch1}} & $past({tx_pos_ch1, tx_neg_ch1})))
        else $error("ch1 line data wrong");
    line_data0_a: assert property (@(posedge aclk) disable iff (!aresetn)
        {line_out_pos_ch0, line_out_neg_ch0} ==
        ({2{line_out_oe_ch0}} & $past({tx_pos_ch0, tx_neg_ch0})))
        else $error("ch0 line data wrong");
    upper_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && (ar_q == gate_a || ar_q == pend_a) |-> s_axi_rdata[31:3] == 29'h0)
        else $error("unused bits read nonzero");
    pend_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && ar_q == pend_a |-> (s_axi_rdata[2:0] & ~ev_q) == 3'h0)
        else $error("pending without event");
    irq_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq |-> ev_q != 3'h0)
        else $error("irq without event");
endmodule

bind tx_driver_enable_and_block_irq irq_gate_chk u_irq_gate_chk (.*);

/* File: tx_driver_enable_and_block_irq_tb.sv */
`timescale 1ns/1ps
`include "irq_gate_defs.vh"

module tx_driver_enable_and_block_irq_tb;
    localparam [7:0] a_pwr = `IDX_LINE_SECTION_POWER << `WORD_SHIFT;
    localparam [7:0] a_sen = `IDX_SRC_ENABLE_BASE << `WORD_SHIFT;
    localparam [7:0] a_sst = `IDX_SRC_STATUS_BASE << `WORD_SHIFT;
    localparam [7:0] a_gate = `IDX_CHANNEL_IRQ_GATE << `WORD_SHIFT;
    localparam [7:0] a_pend = `IDX_CHANNEL_IRQ_PENDING << `WORD_SHIFT;
    localparam [7:0] a_evs = `IDX_IRQ_EVENT_STATUS << `WORD_SHIFT;
    localparam [7:0] a_evm = `IDX_IRQ_EVENT_MASK << `WORD_SHIFT;
    localparam [1:0] ok = `RESP_OKAY;
    localparam [1:0] er = `RESP_SLVERR;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, driver_on_pin_ch1 = 0, driver_on_pin_ch0 = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [11:0] src_event = 0;
    logic [3:0] tx = 0, old, cur;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, pins, on;
    logic [31:0] s_axi_rdata;
    logic line_out_pos_ch1, line_out_neg_ch1, line_out_oe_ch1;
    logic line_out_pos_ch0, line_out_neg_ch0, line_out_oe_ch0;
    int n_fail = 0, samples_checked = 0, i, c, s;

    tx_driver_enable_and_block_irq u_tx_driver_enable_and_block_irq (
        .*,
        .tx_pos_ch1 (tx[3]),
        .tx_neg_ch1 (tx[2]),
        .tx_pos_ch0 (tx[1]),
        .tx_neg_ch0 (tx[0])
    );

    always #12.5 aclk = ~aclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task test_done;
        if (n_fail == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Address and data offered together, each released on its own ready
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        logic ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (s_axi_awready && !ad)
            begin
                ad = 1;
                s_axi_awvalid <= 0;
            end
            if (s_axi_wready && !wd)
            begin
                wd = 1;
                s_axi_wvalid <= 0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        chk(s_axi_bresp, r);
        s_axi_bready <= 0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, r);
        s_axi_rready <= 0;
    endtask

    // One-cycle pulse on a single source line
    task automatic ev(input int b);
        @(posedge aclk);
        src_event <= 12'h001 << b;
        @(posedge aclk);
        src_event <= 12'h000;
        repeat (4) @(posedge aclk);
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        test_done;
    end

    initial
    begin
        void'($urandom(58));
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(a_gate, 0, ok);
        rd(a_pend, 0, ok);
        chk(irq, 0);
        wr(a_gate, 8'hFF, ok);
        rd(a_gate, 8'h07, ok);
        wr(a_pend, 8'hFF, er);
        rd(a_pend, 0, ok);
        rd(8'hFC, 0, er);
        for (i = 0; i < 8; i++)
        begin
            pins = i[2] ? 2'b11 : 2'($urandom);
            wr(a_pwr, {6'($urandom), i[1:0]}, ok);
            rd(a_pwr, i[1:0], ok);
            @(posedge aclk);
            // Pins random in the first four passes, both held high in the last four
            driver_on_pin_ch1 <= pins[1];
            driver_on_pin_ch0 <= pins[0];
            repeat (5) @(posedge aclk);
            on = i[1:0] & pins;
            chk(line_out_oe_ch1, on[1]);
            chk(line_out_oe_ch0, on[0]);
            old = tx;
            cur = tx;
            repeat (6)
            begin
                @(posedge aclk);
                chk({line_out_pos_ch1, line_out_neg_ch1, line_out_pos_ch0, line_out_neg_ch0},
                    old & {{2{on[1]}}, {2{on[0]}}});
                old = cur;
                cur = 4'($urandom);
                tx <= cur;
            end
        end
        wr(a_evm, 8'h07, ok);
        for (c = 0; c < 3; c++)
        begin
            s = $urandom_range(3);
            wr(a_sen + 8'(4 * c), 8'h0F, ok);
            wr(a_gate, 0, ok);
            ev(4 * c + s);
            rd(a_pend, 0, ok);
            chk(irq, 0);
            rd(a_sst + 8'(4 * c), 1 << s, ok);
            wr(a_sen + 8'(4 * c), 0, ok);
            wr(a_gate, 8'(1 << c), ok);
            ev(4 * c + s);
            rd(a_pend, 0, ok);
            rd(a_sst + 8'(4 * c), 1 << s, ok);
            wr(a_sen + 8'(4 * c), 8'(1 << s), ok);
            ev(4 * c + s);
            rd(a_pend, 1 << c, ok);
            chk(irq, 1);
            wr(a_evm, 0, ok);
            chk(irq, 0);
            wr(a_evm, 8'h07, ok);
            wr(a_gate, 0, ok);
            rd(a_pend, 1 << c, ok);
            wr(a_evs, 8'h07, ok);
            chk(irq, 0);
            rd(a_sst + 8'(4 * c), 1 << s, ok);
            rd(a_pend, 0, ok);
            wr(a_sen + 8'(4 * c), 0, ok);
        end
        // Status read while the gate is still open must release pending
        wr(a_gate, 8'h01, ok);
        wr(a_sen, 8'h01, ok);
        ev(0);
        rd(a_pend, 8'h01, ok);
        rd(a_sst, 8'h01, ok);
        rd(a_pend, 0, ok);
        // Second reset in mid-run must clear the gate again
        wr(a_gate, 8'h07, ok);
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(a_gate, 0, ok);
        rd(a_pwr, 0, ok);
        test_done;
    end
endmodule
